// ==== shared/pme_pkg.sv ====
package pme_pkg;
  // Programming memory map
  localparam logic [13:0] PME_USER_ID_FIRST = 14'h2000;
  localparam logic [13:0] PME_USER_ID_LAST = 14'h2003;
  localparam int PME_USER_ID_COUNT = 4;
  localparam int PME_USER_ID_USED_BITS = 4;
  // Register offsets on the plain register port
  localparam logic [3:0] PME_OFF_CONFIG = 4'h0;
  localparam logic [3:0] PME_OFF_STATUS = 4'h1;
  localparam logic [3:0] PME_OFF_ID_BASE = 4'h4;
  // Config register fields
  localparam int PME_CFG_LVP_BIT = 0;
  localparam int PME_CFG_CP_BIT = 1;
  // Values after reset: erased state has the low-voltage enable set, protection off
  localparam logic PME_LVP_RESET = 1'b1;
  localparam logic PME_CP_RESET = 1'b0;
  localparam logic [13:0] PME_ID_RESET = 14'h3FFF;
  // Status fields
  localparam int PME_ST_PROG_BIT = 0;
  localparam int PME_ST_HV_BIT = 1;
  localparam int PME_ST_RUN_BIT = 2;
  // Programming command port codes
  localparam logic [1:0] PME_CMD_READ = 2'h0;
  localparam logic [1:0] PME_CMD_WRITE = 2'h1;
  localparam logic [1:0] PME_CMD_CFG = 2'h2;

  typedef enum logic [1:0] {
    PME_ST_RUN = 2'b00,
    PME_ST_HOLD = 2'b01,
    PME_ST_PROG_LV = 2'b10,
    PME_ST_PROG_HV = 2'b11
  } pme_state_t;
endpackage

// ==== rtl/pme_entry_ctrl.sv ====
`timescale 1ns/10ps
module pme_entry_ctrl
  import pme_pkg::*;
#(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic master_clear_pin,
  input wire logic high_prog_voltage,
  input wire logic prog_select_pin,
  input wire logic serial_prog_clock,
  input wire logic serial_prog_data,
  input wire logic portb_bit3_out,
  input wire logic portb_bit3_dir,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic cpu_run,
  output logic prog_mode,
  output logic prog_clk_sync,
  output logic prog_data_sync,
  output logic prog_data_out,
  output logic prog_data_oe_n,
  output logic portb_bit3_pin_out,
  output logic portb_bit3_pin_oe_n,
  output logic portb_bit3_in,
  output logic [DATA_W-1:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_refused,
  output logic low_voltage_prog_enable
);
  initial begin
    if (DATA_W < PME_USER_ID_USED_BITS || ADDR_W < 14) begin
      $error("pme_entry_ctrl: widths too small");
    end
  end

  function automatic logic is_user_id(input logic [ADDR_W-1:0] a);
    return (a[13:0] >= PME_USER_ID_FIRST) && (a[13:0] <= PME_USER_ID_LAST);
  endfunction

  // Two-flop synchronisers for pins
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else if (clk_en) begin
      sync1_reg <= {serial_prog_data, serial_prog_clock, prog_select_pin,
                    high_prog_voltage, master_clear_pin};
      sync2_reg <= sync1_reg;
    end
  end
  logic master_clear_pin_s, hv_s, sel_s, pclk_s, pdat_s;
  assign master_clear_pin_s = sync2_reg[0];
  assign hv_s = sync2_reg[1];
  assign sel_s = sync2_reg[2];
  assign pclk_s = sync2_reg[3];
  assign pdat_s = sync2_reg[4];

  // Nonvolatile configuration
  logic lvp_reg;
  logic cp_reg;
  pme_state_t state_reg;
  logic in_prog;
  assign in_prog = (state_reg == PME_ST_PROG_LV) || (state_reg == PME_ST_PROG_HV);

  // Entry state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= PME_ST_RUN;
    end else if (clk_en) begin
      case (state_reg)
        PME_ST_RUN: begin
          if (hv_s) begin
            state_reg <= PME_ST_PROG_HV;
          end else if (!master_clear_pin_s) begin
            state_reg <= PME_ST_HOLD;
          end
        end
        PME_ST_HOLD: begin
          if (hv_s) begin
            state_reg <= PME_ST_PROG_HV;
          end else if (master_clear_pin_s && lvp_reg && sel_s) begin
            state_reg <= PME_ST_PROG_LV;
          end else if (master_clear_pin_s) begin
            state_reg <= PME_ST_RUN;
          end
        end
        PME_ST_PROG_LV: begin
          if (hv_s) begin
            state_reg <= PME_ST_PROG_HV;
          end else if (!master_clear_pin_s) begin
            state_reg <= PME_ST_HOLD;
          end
        end
        PME_ST_PROG_HV: begin
          if (!hv_s && !master_clear_pin_s) begin
            state_reg <= PME_ST_HOLD;
          end
        end
        default: begin
          state_reg <= PME_ST_RUN;
        end
      endcase
    end
  end

  // Configuration bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvp_reg <= PME_LVP_RESET;
      cp_reg <= PME_CP_RESET;
    end else if (clk_en && cmd_valid && cmd_op == PME_CMD_CFG && in_prog) begin
      if (state_reg == PME_ST_PROG_HV) begin
        lvp_reg <= cmd_wdata[PME_CFG_LVP_BIT];
      end
      cp_reg <= cmd_wdata[PME_CFG_CP_BIT];
    end
  end

  // User ID words
  logic [DATA_W-1:0] id_mem [PME_USER_ID_COUNT];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PME_USER_ID_COUNT; i++) begin
        id_mem[i] <= DATA_W'(PME_ID_RESET);
      end
    end else if (clk_en && in_prog && cmd_valid && cmd_op == PME_CMD_WRITE
                 && is_user_id(cmd_addr)) begin
      id_mem[cmd_addr[1:0]] <= cmd_wdata;
    end
  end

  // Programming read path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_rdata <= '0;
      cmd_rvalid <= 1'b0;
      cmd_refused <= 1'b0;
    end else if (clk_en) begin
      cmd_rvalid <= 1'b0;
      cmd_refused <= 1'b0;
      if (cmd_valid && !in_prog) begin
        cmd_refused <= 1'b1;
      end else if (cmd_valid && cmd_op == PME_CMD_READ) begin
        if (is_user_id(cmd_addr)) begin
          cmd_rdata <= id_mem[cmd_addr[1:0]];
          cmd_rvalid <= 1'b1;
        end else if (!cp_reg) begin
          cmd_rdata <= mem_rdata;
          cmd_rvalid <= 1'b1;
        end else begin
          cmd_rdata <= '0;
          cmd_refused <= 1'b1;
        end
      end
    end
  end

  // Mode outputs and serial line routing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_run <= 1'b0;
      prog_mode <= 1'b0;
      prog_clk_sync <= 1'b0;
      prog_data_sync <= 1'b0;
      prog_data_out <= 1'b0;
      prog_data_oe_n <= 1'b1;
      low_voltage_prog_enable <= PME_LVP_RESET;
    end else if (clk_en) begin
      cpu_run <= (state_reg == PME_ST_RUN);
      prog_mode <= in_prog;
      prog_clk_sync <= in_prog & pclk_s;
      prog_data_sync <= in_prog & pdat_s;
      prog_data_out <= cmd_rdata[0];
      prog_data_oe_n <= !(in_prog && cmd_rvalid);
      low_voltage_prog_enable <= lvp_reg;
    end
  end

  // Select pin as port bit 3 when low-voltage enable is clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      portb_bit3_pin_out <= 1'b0;
      portb_bit3_pin_oe_n <= 1'b1;
      portb_bit3_in <= 1'b0;
    end else if (clk_en) begin
      if (lvp_reg) begin
        portb_bit3_pin_oe_n <= 1'b1;
        portb_bit3_pin_out <= 1'b0;
        portb_bit3_in <= 1'b0;
      end else begin
        portb_bit3_pin_oe_n <= portb_bit3_dir;
        portb_bit3_pin_out <= portb_bit3_out;
        portb_bit3_in <= sel_s;
      end
    end
  end

  // Register port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          PME_OFF_CONFIG: begin
            reg_rdata[PME_CFG_LVP_BIT] <= lvp_reg;
            reg_rdata[PME_CFG_CP_BIT] <= cp_reg;
          end
          PME_OFF_STATUS: begin
            reg_rdata[PME_ST_PROG_BIT] <= in_prog;
            reg_rdata[PME_ST_HV_BIT] <= (state_reg == PME_ST_PROG_HV);
            reg_rdata[PME_ST_RUN_BIT] <= (state_reg == PME_ST_RUN);
          end
          default: begin
            if (in_prog && reg_addr[3:2] == PME_OFF_ID_BASE[3:2]) begin
              reg_rdata <= 16'(id_mem[reg_addr[1:0]]);
            end
          end
        endcase
      end
    end
  end

  // Register writes have no effect: configuration changes only by programming
  logic unused_wr;
  assign unused_wr = reg_wr & (|reg_wdata);

  // Assertions
  sequence lv_entry_s;
    state_reg == PME_ST_HOLD && master_clear_pin_s && lvp_reg && sel_s && !hv_s;
  endsequence

  sequence hold_s;
    state_reg == PME_ST_HOLD;
  endsequence

  sequence run_s;
    state_reg == PME_ST_RUN;
  endsequence

  hv_entry_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && hv_s |=> state_reg == PME_ST_PROG_HV)
    else $error("high voltage did not enter programming");

  lv_entry_a: assert property (@(posedge clk) disable iff (rst)
    (clk_en and lv_entry_s) |=> state_reg == PME_ST_PROG_LV)
    else $error("low voltage entry missed");

  hold_entry_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && state_reg == PME_ST_RUN && !hv_s && !master_clear_pin_s |=> hold_s)
    else $error("master clear low did not hold");

  lv_refuse_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && state_reg == PME_ST_HOLD && master_clear_pin_s && !lvp_reg && !hv_s |=> run_s)
    else $error("low voltage entry not refused");

  lv_exit_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && state_reg == PME_ST_PROG_LV && !hv_s && !master_clear_pin_s |=> hold_s)
    else $error("programming mode not left");

  run_out_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && state_reg == PME_ST_RUN |=> cpu_run && !prog_mode)
    else $error("execution not running in run state");

  line_gate_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && !in_prog |=> !prog_clk_sync && !prog_data_sync)
    else $error("serial lines routed outside programming");

  data_release_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && !(in_prog && cmd_rvalid) |=> prog_data_oe_n)
    else $error("data line driven without an answer");

  id_write_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && in_prog && cmd_valid && cmd_op == PME_CMD_WRITE && is_user_id(cmd_addr)
    |=> id_mem[$past(cmd_addr[1:0])] == $past(cmd_wdata))
    else $error("user ID word not written");

  id_read_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && in_prog && cmd_valid && cmd_op == PME_CMD_READ && is_user_id(cmd_addr)
    |=> cmd_rvalid && !cmd_refused)
    else $error("user ID word not readable");

  open_read_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && in_prog && cmd_valid && cmd_op == PME_CMD_READ && !cp_reg
    && !is_user_id(cmd_addr) |=> cmd_rvalid && cmd_rdata == $past(mem_rdata))
    else $error("unprotected memory not read out");

  lvp_out_a: assert property (@(posedge clk) disable iff (rst)
    clk_en |=> low_voltage_prog_enable == $past(lvp_reg))
    else $error("enable output does not follow");

  reg_idle_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("register data without a read");

  freeze_a: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> $stable(state_reg) && $stable(lvp_reg) && $stable(cp_reg))
    else $error("state moved while clock enable low");

  lv_block_a: assert property (@(posedge clk) disable iff (rst)
    !lvp_reg && !$past(lvp_reg) |-> state_reg != PME_ST_PROG_LV)
    else $error("low voltage entry with enable cleared");
  lvp_change_a: assert property (@(posedge clk) disable iff (rst)
    $changed(lvp_reg) |-> $past(state_reg) == PME_ST_PROG_HV)
    else $error("enable changed outside high voltage mode");
  cp_read_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && cmd_valid && in_prog && cmd_op == PME_CMD_READ && cp_reg
    && !is_user_id(cmd_addr) |=> !cmd_rvalid && cmd_refused)
    else $error("protected memory read out");
  id_gate_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && cmd_valid && !in_prog |=> cmd_refused && !cmd_rvalid)
    else $error("access outside programming mode");
  pin_dedicated_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && lvp_reg |=> portb_bit3_pin_oe_n && !portb_bit3_in)
    else $error("select pin used as I/O while dedicated");
  cpu_hold_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && in_prog |=> !cpu_run && prog_mode)
    else $error("execution not held in programming mode");
  pin_gpio_a: assert property (@(posedge clk) disable iff (rst)
    clk_en && !lvp_reg |=> portb_bit3_pin_oe_n == $past(portb_bit3_dir))
    else $error("port bit 3 direction not followed");
endmodule

// ==== testbench/pme_prog_model.sv ====
`timescale 1ns/10ps
module pme_prog_model (
  input wire logic clk,
  input wire logic prog_data_out,
  input wire logic prog_data_oe_n,
  output logic master_clear_pin,
  output logic high_prog_voltage,
  output logic prog_select_pin,
  output logic serial_prog_clock,
  output logic serial_prog_data
);
  logic drv_bit = 1'b0;
  initial begin
    master_clear_pin = 1'b1;
    high_prog_voltage = 1'b0;
    prog_select_pin = 1'b0;
    serial_prog_clock = 1'b0;
  end
  // Programmer drives data while the device releases it
  assign serial_prog_data = prog_data_oe_n ? drv_bit : prog_data_out;
  task automatic lv_enter();
    @(posedge clk);
    master_clear_pin <= 1'b0;
    repeat (6) @(posedge clk);
    prog_select_pin <= 1'b1;
    repeat (6) @(posedge clk);
    master_clear_pin <= 1'b1;
  endtask
  task automatic hv_enter();
    @(posedge clk);
    master_clear_pin <= 1'b0;
    repeat (6) @(posedge clk);
    high_prog_voltage <= 1'b1;
    master_clear_pin <= 1'b1;
  endtask
  task automatic leave();
    @(posedge clk);
    high_prog_voltage <= 1'b0;
    prog_select_pin <= 1'b0;
    master_clear_pin <= 1'b0;
    repeat (8) @(posedge clk);
    master_clear_pin <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // Burst at 160 ns, clock idle low outside it
  task automatic frame(input int n);
    #7;
    repeat (n) begin
      drv_bit = ~drv_bit;
      #80 serial_prog_clock = 1'b1;
      #80 serial_prog_clock = 1'b0;
    end
  endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import pme_pkg::*;
  logic clk, rst, portb_bit3_out, portb_bit3_dir, cmd_valid, reg_wr, reg_rd, clk_seen;
  logic dat_seen;
  logic [1:0] cmd_op;
  logic [13:0] cmd_addr, cmd_wdata, cmd_rdata;
  logic [13:0] mem_rdata = 14'h1234;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic master_clear_pin, high_prog_voltage, prog_select_pin, serial_prog_clock;
  logic serial_prog_data, cpu_run, prog_mode, prog_clk_sync, prog_data_sync;
  logic prog_data_out, prog_data_oe_n, portb_bit3_pin_out, portb_bit3_pin_oe_n;
  logic portb_bit3_in, cmd_rvalid, cmd_refused, low_voltage_prog_enable;
  int error_cnt = 0;
  int checks = 0;
  pme_entry_ctrl pme_entry_ctrl_inst (.clk, .rst, .clk_en(1'b1), .master_clear_pin,
    .high_prog_voltage, .prog_select_pin, .serial_prog_clock, .serial_prog_data,
    .portb_bit3_out, .portb_bit3_dir, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata,
    .mem_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_run,
    .prog_mode, .prog_clk_sync, .prog_data_sync, .prog_data_out, .prog_data_oe_n,
    .portb_bit3_pin_out, .portb_bit3_pin_oe_n, .portb_bit3_in, .cmd_rdata,
    .cmd_rvalid, .cmd_refused, .low_voltage_prog_enable);
  pme_prog_model pme_prog_model_inst (.clk, .prog_data_out, .prog_data_oe_n,
    .master_clear_pin, .high_prog_voltage, .prog_select_pin, .serial_prog_clock,
    .serial_prog_data);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (prog_clk_sync === 1'b1) begin
      clk_seen <= 1'b1;
    end
    if (prog_data_sync === 1'b1) begin
      dat_seen <= 1'b1;
    end
  end
  task automatic test_done();
    $display("TB: checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Expect {rvalid, refused, data}
  task automatic cmd(input logic [1:0] op, input logic [13:0] a, input logic [13:0] wd,
    input logic [15:0] exp);
    @(posedge clk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= wd;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    chk({cmd_rvalid, cmd_refused, cmd_rvalid ? cmd_rdata : 14'h0000}, exp);
  endtask
  task automatic wait_prog(input logic exp);
    for (int i = 0; i < 30 && prog_mode !== exp; i++) begin
      @(negedge clk);
    end
    chk({15'h0, prog_mode}, {15'h0, exp});
    if (prog_mode !== exp) begin
      test_done();
    end
  endtask
  task automatic burst(input logic exp);
    @(negedge clk);
    clk_seen = 1'b0;
    dat_seen = 1'b0;
    pme_prog_model_inst.frame(4);
    repeat (4) @(posedge clk);
    chk({14'h0, clk_seen, dat_seen}, {14'h0, exp, exp});
  endtask
  initial begin
    rst = 1'b1;
    {portb_bit3_out, portb_bit3_dir, cmd_valid, reg_wr, reg_rd, clk_seen} = 6'h01;
    {cmd_op, cmd_addr, cmd_wdata, reg_addr, reg_wdata} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({15'h0, low_voltage_prog_enable}, 16'h0001);
    rd(PME_OFF_CONFIG, 16'h0001);
    rd(PME_OFF_STATUS, 16'h0004);
    rd(PME_OFF_ID_BASE + 4'h1, 16'h0000);
    rd(4'h3, 16'h0000);
    cmd(PME_CMD_READ, PME_USER_ID_FIRST, 14'h0000, 16'h4000);
    burst(1'b0);
    $display("TB: reset test done");
    portb_bit3_dir <= 1'b0;
    pme_prog_model_inst.lv_enter();
    wait_prog(1'b1);
    chk({14'h0, cpu_run, portb_bit3_pin_oe_n}, 16'h0001);
    rd(PME_OFF_STATUS, 16'h0001);
    burst(1'b1);
    cmd(PME_CMD_WRITE, PME_USER_ID_LAST, 14'h000A, 16'h0000);
    cmd(PME_CMD_READ, PME_USER_ID_LAST, 14'h0000, 16'h800A);
    @(negedge clk);
    chk({14'h0, prog_data_oe_n, prog_data_out}, 16'h0000);
    rd(PME_OFF_ID_BASE + 4'h3, 16'h000A);
    cmd(PME_CMD_READ, 14'h0000, 14'h0000, 16'h9234);
    cmd(PME_CMD_CFG, 14'h0000, 14'h0002, 16'h0000);
    chk({15'h0, low_voltage_prog_enable}, 16'h0001);
    cmd(PME_CMD_READ, 14'h0000, 14'h0000, 16'h4000);
    wr(PME_OFF_CONFIG, 16'h0000);
    rd(PME_OFF_CONFIG, 16'h0003);
    pme_prog_model_inst.leave();
    chk({14'h0, cpu_run, prog_mode}, 16'h0002);
    $display("TB: low-voltage test done");
    pme_prog_model_inst.hv_enter();
    wait_prog(1'b1);
    rd(PME_OFF_STATUS, 16'h0003);
    cmd(PME_CMD_CFG, 14'h0000, 14'h0000, 16'h0000);
    @(negedge clk);
    chk({15'h0, low_voltage_prog_enable}, 16'h0000);
    cmd(PME_CMD_READ, 14'h0005, 14'h0000, 16'h9234);
    portb_bit3_out <= 1'b1;
    pme_prog_model_inst.leave();
    chk({13'h0, portb_bit3_pin_oe_n, portb_bit3_pin_out, portb_bit3_in}, 16'h0002);
    pme_prog_model_inst.lv_enter();
    repeat (10) @(posedge clk);
    chk({14'h0, prog_mode, portb_bit3_in}, 16'h0001);
    pme_prog_model_inst.leave();
    pme_prog_model_inst.hv_enter();
    wait_prog(1'b1);
    pme_prog_model_inst.leave();
    $display("TB: high-voltage test done");
    test_done();
  end
endmodule
